//--- dea_pkg.sv
// shared constants, register map and carrier types for the data eeprom access controller
`default_nettype none

package dea_pkg;

  localparam int unsigned DEA_APB_AW   = 12;
  localparam int unsigned DEA_BYTE_W   = 8;
  localparam int unsigned DEA_DEPTH    = 256;
  localparam int unsigned DEA_NV_AW    = 8;
  localparam int unsigned DEA_CNT_W    = 16;

  // register byte offsets on the bus
  localparam logic [11:0] DEA_OFS_ADDR   = 12'h000;
  localparam logic [11:0] DEA_OFS_DATA   = 12'h004;
  localparam logic [11:0] DEA_OFS_CTRL   = 12'h008;
  localparam logic [11:0] DEA_OFS_UNLOCK = 12'h00C;

  // control register fields
  localparam int unsigned DEA_CTL_RD     = 0;
  localparam int unsigned DEA_CTL_WR     = 1;
  localparam int unsigned DEA_CTL_WRITE_ENABLE_BIT   = 2;
  localparam int unsigned DEA_CTL_DONE   = 3;
  localparam int unsigned DEA_CTL_REFUSE = 4;
  localparam int unsigned DEA_CTL_PSEL   = 7;

  // reset values
  localparam logic [7:0] DEA_RST_ADDR = 8'h00;
  localparam logic [7:0] DEA_RST_DATA = 8'h00;
  localparam logic       DEA_RST_BIT  = 1'b0;

  // unlock keys
  localparam logic [7:0] DEA_KEY_FIRST  = 8'h55;
  localparam logic [7:0] DEA_KEY_SECOND = 8'hAA;

  // write cycle length
  localparam int unsigned DEA_CLK_PERIOD_NS = 20;
  localparam int unsigned DEA_WRITE_TIME_NS = 4000;
  localparam int unsigned DEA_WRITE_CYCLES  = DEA_WRITE_TIME_NS / DEA_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    DEA_REG_ADDR,
    DEA_REG_DATA,
    DEA_REG_CTRL,
    DEA_REG_UNLOCK,
    DEA_REG_NONE
  } dea_reg_sel_t;

  typedef enum logic [1:0] {
    DEA_UNL_IDLE,
    DEA_UNL_KEY1,
    DEA_UNL_ARMED
  } dea_unl_step_t;

  typedef enum logic {
    DEA_WR_IDLE,
    DEA_WR_BUSY
  } dea_wr_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } dea_apb_req_t;

  typedef struct packed {
    logic [7:0]    addr;
    logic [7:0]    data;
    logic          write_enable_bit;
    logic          prog_sel;
    logic          done_flag;
    logic          refused;
    dea_wr_state_t wr_state;
    logic [15:0]   cnt;
    logic [31:0]   prdata;
    logic          pslverr;
  } dea_ctrl_state_t;

  typedef struct packed {
    dea_unl_step_t step;
  } dea_unl_state_t;

  function automatic dea_reg_sel_t dea_decode(input logic [11:0] a);
    dea_reg_sel_t s;
    case (a)
      DEA_OFS_ADDR:   s = DEA_REG_ADDR;
      DEA_OFS_DATA:   s = DEA_REG_DATA;
      DEA_OFS_CTRL:   s = DEA_REG_CTRL;
      DEA_OFS_UNLOCK: s = DEA_REG_UNLOCK;
      default:        s = DEA_REG_NONE;
    endcase
    return s;
  endfunction

endpackage

`default_nettype wire

//--- dea_unlock_seq.sv
// unlock key tracker: arms after the two keys arrive back to back
`timescale 1ns/100ps
`default_nettype none

module dea_unlock_seq (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_unlock_wr,
  input  wire logic [7:0] i_unlock_data,
  input  wire logic       i_other_wr,
  output logic            o_armed
);

  dea_pkg::dea_unl_state_t s_q;
  dea_pkg::dea_unl_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (i_unlock_wr) begin
      if (i_unlock_data == dea_pkg::DEA_KEY_FIRST) begin
        s_d.step = dea_pkg::DEA_UNL_KEY1;
      end else if (s_q.step == dea_pkg::DEA_UNL_KEY1 &&
                   i_unlock_data == dea_pkg::DEA_KEY_SECOND) begin
        s_d.step = dea_pkg::DEA_UNL_ARMED;
      end else begin
        s_d.step = dea_pkg::DEA_UNL_IDLE;
      end
    end else if (i_other_wr) begin
      // any other write breaks the sequence, including the one that uses it
      s_d.step = dea_pkg::DEA_UNL_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q.step <= dea_pkg::DEA_UNL_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_armed = (s_q.step == dea_pkg::DEA_UNL_ARMED);

endmodule

`default_nettype wire

//--- dea_nv_array.sv
// byte array standing in for the eeprom cells, flip-flop storage
`timescale 1ns/100ps
`default_nettype none

module dea_nv_array #(
  parameter int unsigned WIDTH = dea_pkg::DEA_BYTE_W,
  parameter int unsigned DEPTH = dea_pkg::DEA_DEPTH,
  parameter int unsigned AW    = dea_pkg::DEA_NV_AW
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [AW-1:0]    i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } dea_arr_state_t;

  dea_arr_state_t s_q;
  dea_arr_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (i_we) begin
      s_d.mem[i_waddr] = i_wdata;
    end
  end

  // no reset on purpose: contents are meant to survive a device reset
  always_ff @(posedge i_ref_clk) begin
    s_q <= s_d;
  end

  assign o_rdata = s_q.mem[i_raddr];

endmodule

`default_nettype wire

//--- dea_eeprom_ctrl.sv
// data eeprom access controller: apb register file, read strobe, locked write cycle
//
// Function
// - A read strobe puts the addressed byte into the data register by the next access.
// - The data register holds a read result until the next read or a software write to it.
// - A write starts only after 55h then 0AAh to the unlock register and then the write strobe.
// - Writes are allowed only while write enable is set; otherwise write attempts start no write and set the refuse flag.
// - Write enable is never cleared by hardware, not even when a write cycle ends.
// - During a write cycle control, address and data registers cannot be changed.
// - The write strobe can only become set while write enable is already set.
// - Setting write enable and write strobe in one access starts no write.
// - At the end of a write cycle the write strobe clears and the done flag sets.
// - The done flag stays set until software clears it; software may poll it.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none

module dea_eeprom_ctrl #(
  parameter int unsigned WRITE_CYCLES = dea_pkg::DEA_WRITE_CYCLES
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire dea_pkg::dea_apb_req_t i_apb,
  output logic [31:0]               o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  output logic                      o_write_busy,
  output logic                      o_write_done
);

  localparam logic [15:0] LAST_CNT = 16'(WRITE_CYCLES - 1);

  dea_pkg::dea_ctrl_state_t s_q;
  dea_pkg::dea_ctrl_state_t s_d;

  logic                 setup_phase;
  logic                 wr_access;
  dea_pkg::dea_reg_sel_t setup_sel;
  dea_pkg::dea_reg_sel_t acc_sel;
  logic                 lane0;
  logic [7:0]           wbyte;
  logic                 busy;
  logic                 armed;
  logic                 unlock_wr;
  logic                 other_wr;
  logic                 commit;
  logic [7:0]           arr_rdata;
  logic [7:0]           ctrl_view;

  assign setup_phase = i_apb.psel & ~i_apb.penable;
  assign wr_access   = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign setup_sel   = dea_pkg::dea_decode(i_apb.paddr);
  assign acc_sel     = dea_pkg::dea_decode(i_apb.paddr);
  assign lane0       = i_apb.pstrb[0];
  assign wbyte       = i_apb.pwdata[7:0];
  assign busy        = (s_q.wr_state == dea_pkg::DEA_WR_BUSY);
  assign unlock_wr   = wr_access & lane0 & (acc_sel == dea_pkg::DEA_REG_UNLOCK);
  assign other_wr    = wr_access & ~unlock_wr;
  assign commit      = busy & (s_q.cnt == LAST_CNT);

  // the strobe bit reads back as the running write cycle
  always_comb begin
    ctrl_view                          = 8'h00;
    ctrl_view[dea_pkg::DEA_CTL_WR]     = busy;
    ctrl_view[dea_pkg::DEA_CTL_WRITE_ENABLE_BIT]   = s_q.write_enable_bit;
    ctrl_view[dea_pkg::DEA_CTL_DONE]   = s_q.done_flag;
    ctrl_view[dea_pkg::DEA_CTL_REFUSE] = s_q.refused;
    ctrl_view[dea_pkg::DEA_CTL_PSEL]   = s_q.prog_sel;
  end

  dea_unlock_seq u_unlock (
    .i_ref_clk     (i_ref_clk),
    .i_rst         (i_rst),
    .i_unlock_wr   (unlock_wr),
    .i_unlock_data (wbyte),
    .i_other_wr    (other_wr),
    .o_armed       (armed)
  );

  dea_nv_array u_array (
    .i_ref_clk (i_ref_clk),
    .i_we      (commit),
    .i_waddr   (s_q.addr),
    .i_wdata   (s_q.data),
    .i_raddr   (s_q.addr),
    .o_rdata   (arr_rdata)
  );

  always_comb begin
    s_d = s_q;

    // read data and error are captured in the setup cycle for a zero-wait access
    if (setup_phase) begin
      s_d.pslverr = (setup_sel == dea_pkg::DEA_REG_NONE);
      case (setup_sel)
        dea_pkg::DEA_REG_ADDR: begin
          s_d.prdata = {24'h000000, s_q.addr};
        end
        dea_pkg::DEA_REG_DATA: begin
          s_d.prdata = {24'h000000, s_q.data};
        end
        dea_pkg::DEA_REG_CTRL: begin
          s_d.prdata = {24'h000000, ctrl_view};
        end
        default: begin
          s_d.prdata = 32'h00000000;
        end
      endcase
    end

    if (wr_access && lane0) begin
      case (acc_sel)
        dea_pkg::DEA_REG_ADDR: begin
          if (!busy) begin
            s_d.addr = wbyte;
          end
        end
        dea_pkg::DEA_REG_DATA: begin
          if (!busy) begin
            s_d.data = wbyte;
          end
        end
        dea_pkg::DEA_REG_CTRL: begin
          if (!busy) begin
            // only software changes write_enable_bit: hardware never clears it
            s_d.write_enable_bit     = wbyte[dea_pkg::DEA_CTL_WRITE_ENABLE_BIT];
            s_d.prog_sel = wbyte[dea_pkg::DEA_CTL_PSEL];
            // flags clear on a written zero, a written one leaves them alone
            s_d.done_flag = s_q.done_flag & wbyte[dea_pkg::DEA_CTL_DONE];
            s_d.refused   = s_q.refused & wbyte[dea_pkg::DEA_CTL_REFUSE];
            if (wbyte[dea_pkg::DEA_CTL_WR] && !wbyte[dea_pkg::DEA_CTL_PSEL]) begin
              // old write_enable_bit must already be set, so a combined set cannot start
              if (s_q.write_enable_bit && wbyte[dea_pkg::DEA_CTL_WRITE_ENABLE_BIT] && armed) begin
                s_d.wr_state = dea_pkg::DEA_WR_BUSY;
                s_d.cnt      = 16'h0000;
              end else begin
                s_d.refused = 1'b1;
              end
            end else if (wbyte[dea_pkg::DEA_CTL_RD] && !wbyte[dea_pkg::DEA_CTL_PSEL]) begin
              // program memory is not behind this block, so select=1 reads nothing
              s_d.data = arr_rdata;
            end
          end
        end
        default: begin
          s_d.pslverr = s_q.pslverr;
        end
      endcase
    end

    // completion after all software effects so the hardware set wins
    if (busy) begin
      if (commit) begin
        s_d.wr_state  = dea_pkg::DEA_WR_IDLE;
        s_d.cnt       = 16'h0000;
        s_d.done_flag = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q.addr      <= dea_pkg::DEA_RST_ADDR;
      s_q.data      <= dea_pkg::DEA_RST_DATA;
      s_q.write_enable_bit      <= dea_pkg::DEA_RST_BIT;
      s_q.prog_sel  <= dea_pkg::DEA_RST_BIT;
      s_q.done_flag <= dea_pkg::DEA_RST_BIT;
      s_q.refused   <= dea_pkg::DEA_RST_BIT;
      s_q.wr_state  <= dea_pkg::DEA_WR_IDLE;
      s_q.cnt       <= 16'h0000;
      s_q.prdata    <= 32'h00000000;
      s_q.pslverr   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pready     = i_apb.psel & i_apb.penable;
  assign o_prdata     = s_q.prdata;
  assign o_pslverr    = s_q.pslverr & i_apb.psel & i_apb.penable;
  assign o_write_busy = busy;
  assign o_write_done = s_q.done_flag;

endmodule

`default_nettype wire

//--- dea_eeprom_ctrl_properties.sv
// port assertions for the data eeprom access controller
`timescale 1ns/100ps
`default_nettype none
module dea_ctrl_chk #(
  parameter int unsigned WRITE_CYCLES = dea_pkg::DEA_WRITE_CYCLES
) (
  input wire logic                  i_ref_clk,
  input wire logic                  i_rst,
  input wire dea_pkg::dea_apb_req_t i_apb,
  input wire logic [31:0]           o_prdata,
  input wire logic                  o_pready,
  input wire logic                  o_pslverr,
  input wire logic                  o_write_busy,
  input wire logic                  o_write_done
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic        acc;
  logic        wr;
  logic        rd_ctl;
  logic        unl;
  logic        key1_q;
  logic        key2_q;
  logic        write_enable_bit_q;
  logic [15:0] cnt_q;
  logic        ctl_clr;
  assign acc = i_apb.psel & i_apb.penable;
  assign wr = acc & i_apb.pwrite;
  assign rd_ctl = acc & !i_apb.pwrite & (i_apb.paddr == dea_pkg::DEA_OFS_CTRL);
  assign unl = i_apb.paddr == dea_pkg::DEA_OFS_UNLOCK;
  assign ctl_clr = wr & (i_apb.paddr == dea_pkg::DEA_OFS_CTRL) &
                   !i_apb.pwdata[dea_pkg::DEA_CTL_DONE];
  // shadow of the key order and enable bit, any bus write breaks the keys
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      key1_q <= 1'b0;
      key2_q <= 1'b0;
      write_enable_bit_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= o_write_busy ? cnt_q + 16'h0001 : 16'h0000;
      if (wr) begin
        key1_q <= unl && i_apb.pwdata[7:0] == dea_pkg::DEA_KEY_FIRST;
        key2_q <= key1_q && unl && i_apb.pwdata[7:0] == dea_pkg::DEA_KEY_SECOND;
        if (i_apb.paddr == dea_pkg::DEA_OFS_CTRL && !o_write_busy) begin
          write_enable_bit_q <= i_apb.pwdata[dea_pkg::DEA_CTL_WRITE_ENABLE_BIT];
        end
      end
    end
  end
  pready_now_a: assert property (o_pready == acc)
    else $error("pready not in access phase");
  key_start_a: assert property ($rose(o_write_busy) |-> $past(key2_q) && $past(write_enable_bit_q))
    else $error("write cycle began without keys and enable");
  // a reset cuts the cycle short, so the edge right after it is left out
  busy_len_a: assert property (!i_rst && $fell(o_write_busy) |-> cnt_q == 16'(WRITE_CYCLES))
    else $error("write cycle length wrong");
  done_end_a: assert property (!i_rst && $fell(o_write_busy) |-> o_write_done)
    else $error("done flag not set at cycle end");
  done_src_a: assert property ($rose(o_write_done) |-> $fell(o_write_busy))
    else $error("done flag set outside cycle end");
  done_clear_a: assert property (!i_rst && $fell(o_write_done) |-> $past(ctl_clr))
    else $error("done flag cleared without software");
  write_enable_bit_read_a: assert property (rd_ctl |-> o_prdata[2] == $past(write_enable_bit_q))
    else $error("enable bit readback wrong");
  busy_read_a: assert property (rd_ctl |-> o_prdata[1] == $past(o_write_busy))
    else $error("strobe bit readback wrong");
  cover property ($rose(o_write_busy));
  cover property ($fell(o_write_done));
  cover property (rd_ctl && o_prdata[2]);
endmodule
bind dea_eeprom_ctrl dea_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_apb(i_apb), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_write_busy(o_write_busy),
  .o_write_done(o_write_done));
`default_nettype wire

//--- dea_cpu_model.sv
// core side model: issues apb register accesses
`timescale 1ns/100ps
`default_nettype none
module dea_cpu_model (
  input  wire logic                 i_ref_clk,
  input  wire logic [31:0]          i_prdata,
  input  wire logic                 i_pready,
  input  wire logic                 i_pslverr,
  output var dea_pkg::dea_apb_req_t o_apb
);
  initial o_apb = '0;
  // request held until pready seen high, then released
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_ref_clk);
    o_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hF};
    @(posedge i_ref_clk);
    o_apb.penable <= 1'b1;
    do @(posedge i_ref_clk); while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_apb <= '0;
  endtask
endmodule
`default_nettype wire

//--- test_data_eeprom_access_control.sv
// self-checking bench for the data eeprom access controller
`timescale 1ns/100ps
`default_nettype none
module test_data_eeprom_access_control;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  d;
    logic [31:0] q;
    logic        e;
  } dea_row_t;
  localparam logic [11:0] AD = dea_pkg::DEA_OFS_ADDR;
  localparam logic [11:0] DT = dea_pkg::DEA_OFS_DATA;
  localparam logic [11:0] CT = dea_pkg::DEA_OFS_CTRL;
  localparam logic [11:0] UN = dea_pkg::DEA_OFS_UNLOCK;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  dea_pkg::dea_apb_req_t apb;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  busy;
  logic                  done;
  logic [31:0]           q;
  logic                  e;
  int                    error_cnt = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  dea_row_t              rows[6];
  logic [7:0]            pre[4] = '{8'h00, 8'h04, 8'h04, 8'h04};
  logic [7:0]            k1[4] = '{8'h55, 8'hAA, 8'h55, 8'h55};
  logic [7:0]            k2[4] = '{8'hAA, 8'h55, 8'h56, 8'hAA};
  logic [7:0]            st[4] = '{8'h06, 8'h06, 8'h06, 8'h02};
  always #10 clk = ~clk;
  dea_eeprom_ctrl #(.WRITE_CYCLES(12)) dut (.i_ref_clk(clk), .i_rst(rst), .i_apb(apb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_write_busy(busy),
    .o_write_done(done));
  dea_cpu_model cpu (.i_ref_clk(clk), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .o_apb(apb));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cpu.xfer(1'b1, a, 32'(d), q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    cpu.xfer(1'b0, a, 32'h00000000, q, e);
    chk(q, x);
  endtask
  task automatic nv_write(input logic [7:0] a, input logic [7:0] d);
    wr(AD, a);
    wr(DT, d);
    wr(CT, 8'h04);
    wr(UN, 8'h55);
    wr(UN, 8'hAA);
    wr(CT, 8'h06);
    @(negedge clk);
    chk(32'(busy), 32'h00000001);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk(32'(busy), 32'h00000000);
  endtask
  task wrap_up;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    rows[0] = '{AD, 8'hFF, 32'h000000FF, 1'b0};
    rows[1] = '{AD, 8'h00, 32'h00000000, 1'b0};
    rows[2] = '{DT, 8'h5A, 32'h0000005A, 1'b0};
    rows[3] = '{CT, 8'h04, 32'h00000004, 1'b0};
    rows[4] = '{UN, 8'h55, 32'h00000000, 1'b0};
    rows[5] = '{12'h010, 8'hA5, 32'h00000000, 1'b1};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({prdata[29:0], busy, done}, 32'h00000000);
    rd(CT, 32'h00000000);
    foreach (rows[i]) begin
      cpu.xfer(1'b1, rows[i].a, 32'(rows[i].d), q, e);
      chk(32'(e), 32'(rows[i].e));
      cpu.xfer(1'b0, rows[i].a, 32'h00000000, q, e);
      chk(q, rows[i].q);
      chk(32'(e), 32'(rows[i].e));
    end
    nv_write(8'hFF, 8'hA5);
    wr(AD, 8'h00);
    wr(DT, 8'h00);
    wr(CT, 8'h00);
    wait_idle();
    rd(AD, 32'h000000FF);
    rd(CT, 32'h0000000C);
    chk(32'(done), 32'h00000001);
    wr(CT, 8'h04);
    rd(CT, 32'h00000004);
    wr(DT, 8'h00);
    wr(CT, 8'h01);
    rd(DT, 32'h000000A5);
    wr(AD, 8'h00);
    rd(DT, 32'h000000A5);
    // refused starts: no prior enable, keys swapped, bad key, enable dropped
    for (int i = 0; i < 4; i++) begin
      wr(CT, pre[i]);
      wr(UN, k1[i]);
      wr(UN, k2[i]);
      wr(CT, st[i]);
      @(negedge clk);
      chk(32'(busy), 32'h00000000);
    end
    nv_write(8'h00, 8'h3C);
    wait_idle();
    wr(CT, 8'h05);
    rd(DT, 32'h0000003C);
    // program memory select: the read strobe must leave the data register alone
    wr(AD, 8'hFF);
    wr(CT, 8'h81);
    rd(DT, 32'h0000003C);
    rd(CT, 32'h00000080);
    wr(CT, 8'h00);
    nv_write(8'hFF, 8'h11);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({30'h00000000, busy, done}, 32'h00000000);
    rd(CT, 32'h00000000);
    rd(AD, 32'h00000000);
    wrap_up();
  end
endmodule
`default_nettype wire
